// ==== mbx_responder.sv ====
`timescale 1ns/1ns
// Function
// RL1: Values travel as integers scaled by ten to the decimal count.
// RL2: Accepted writes store the received integer as the scaled engineering value.
// RL3: Successful responses echo the request function code unchanged.
// RL4: Failed responses set the function code's top bit.
// RL5: Exception response carries one error code byte then the CRC.
// RL6: Code 01H for unsupported function or faulted drive.
// RL7: Code 02H for disallowed address or address plus length range.
// RL8: Code 03H for a structurally disallowed request data field.
// RL9: Code 04H for a write value outside its setting range.
// RL10: Code 05H when a supplied password mismatches the stored password.
// RL11: Code 06H for wrong frame length or bad CRC.
// RL12: Code 07H, target unchanged, when writing a read-only parameter.
// RL13: Code 08H when writing a stop-only parameter while running.
// RL14: Code 09H when a password is set and access is still locked.
// RL15: Master may resend or change the request after an exception.
// RL16: Responses carry Modbus CRC-16, low byte first.
// RL17: One code per request, in frame, function, address, lock, access, range order.
`include "mbx_defs.svh"
module mbx_responder #(
    parameter logic [7:0] SLAVE_ADDR = 8'h01,
    parameter int AW = 8
) (
    input wire logic mclk,
    input wire logic reset,
    input wire mbx_pkg::mbx_byte_s rx_byte,
    input wire logic rx_valid,
    input wire logic drive_running,
    input wire logic drive_faulted,
    input wire logic [15:0] user_password_setting,
    input wire mbx_pkg::mbx_attr_s attr,
    output logic [AW-1:0] attr_addr_ff,
    output mbx_pkg::mbx_byte_s tx_byte_ff,
    output logic tx_valid_ff,
    output logic unlocked_ff,
    output logic param_wr_ff,
    output logic [15:0] param_wr_value_ff
);
    logic [7:0] buf_ff [8];
    logic [3:0] cnt_ff;
    logic [15:0] crc_ff;
    logic frame_err_ff;
    mbx_pkg::mbx_state_e state_ff;
    logic [7:0] code_ff;
    logic [7:0] exc_ff;
    logic [15:0] rdval_ff;
    logic [3:0] tx_idx_ff;
    logic [15:0] tcrc_ff;
    logic [15:0] ram_rd;

    // Byte-serial CRC-16 step, reflected polynomial.
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `MBX_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // Decoded request fields.
    wire [7:0] req_func = buf_ff[1];
    wire [15:0] req_addr = {buf_ff[2], buf_ff[3]};
    wire [15:0] req_data = {buf_ff[4], buf_ff[5]};
    wire [15:0] rx_crc = {buf_ff[7], buf_ff[6]};
    wire is_read = req_func == `MBX_FC_READ;
    wire is_write = req_func == `MBX_FC_WRITE;
    wire is_pw = req_addr == `MBX_PASSWD_ADDR;
    wire [16:0] end_addr = {1'b0, req_addr} + {1'b0, req_data};
    wire pw_set = user_password_setting != 16'h0000;
    wire [15:0] crc_next = crc_step(crc_ff, rx_byte.data);

    // RL11: length and CRC checks.
    wire e_frame = frame_err_ff || cnt_ff != `MBX_REQ_LEN || crc_ff != 16'h0000;
    // RL6: unsupported or faulted.
    wire e_func = !(is_read || is_write) || drive_faulted;
    // RL7: address window including the span of a read.
    wire e_addr = is_read ? (end_addr > {1'b0, `MBX_PARAM_COUNT})
                          : (req_addr >= `MBX_PARAM_COUNT);
    // RL8: a read quantity of zero or above MBX_MAX_READ_QTY.
    wire e_data = is_read && (req_data == 16'h0000 ||
                              req_data > `MBX_MAX_READ_QTY);
    // RL14: locked unless the password is empty or was given.
    wire e_lock = pw_set && !unlocked_ff && !(is_write && is_pw);
    // RL10: wrong password at the verification address.
    wire e_pw = is_write && is_pw && req_data != user_password_setting;
    // RL12: read-only target.
    wire e_ro = is_write && !is_pw && attr.read_only;
    // RL13: stop-only target while running.
    wire e_run = is_write && !is_pw && attr.stop_only && drive_running;
    // RL9: outside the setting range.
    wire e_rng = is_write && !is_pw &&
                 (req_data < attr.min_val || req_data > attr.max_val);

    // RL17: one code per request, in fixed priority.
    wire [7:0] exc_sel = e_frame ? `MBX_EX_FRAME :
                         e_func ? `MBX_EX_FUNC :
                         e_addr ? `MBX_EX_ADDR :
                         e_data ? `MBX_EX_DATA :
                         e_lock ? `MBX_EX_LOCKED :
                         e_pw ? `MBX_EX_PASSWD :
                         e_ro ? `MBX_EX_RDONLY :
                         e_run ? `MBX_EX_RUNNING :
                         e_rng ? `MBX_EX_RANGE : `MBX_EX_NONE;

    // Response length depends on kind.
    wire [3:0] rsp_len = (exc_ff != `MBX_EX_NONE) ? `MBX_RSP_EXC_LEN :
                         is_read ? `MBX_RSP_RD_LEN : `MBX_RSP_WR_LEN;
    wire [3:0] crc_pos = rsp_len - 4'h2;

    // Body byte selection per response kind.
    logic [7:0] body;
    always_comb begin
        body = 8'h00;
        if (tx_idx_ff == 4'h0) begin
            body = SLAVE_ADDR;
        end else if (tx_idx_ff == 4'h1) begin
            body = code_ff;
        end else if (exc_ff != `MBX_EX_NONE) begin
            body = exc_ff;
        end else if (is_read) begin
            case (tx_idx_ff)
                4'h2: body = 8'h02;
                4'h3: body = rdval_ff[15:8];
                4'h4: body = rdval_ff[7:0];
                default: body = 8'h00;
            endcase
        end else begin
            body = buf_ff[tx_idx_ff[2:0]];
        end
    end
    // RL16: CRC low byte first, then high byte.
    wire [7:0] tx_sel = (tx_idx_ff == crc_pos) ? tcrc_ff[7:0] :
                        (tx_idx_ff > crc_pos) ? tcrc_ff[15:8] : body;
    wire in_body = tx_idx_ff < crc_pos;
    wire accept = !e_frame && exc_sel == `MBX_EX_NONE;

    // The read path uses a registered store, so one wait state is spent.
    mbx_param_ram #(.DEPTH(1 << AW), .AW(AW)) u_ram (
        .mclk(mclk),
        .wr_en(param_wr_ff),
        .wr_addr(attr_addr_ff),
        .wr_data(param_wr_value_ff),
        .rd_addr(attr_addr_ff),
        .rd_data(ram_rd)
    );

    // Receive: collect bytes and run the CRC over the whole frame.
    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt_ff <= 4'h0;
            crc_ff <= `MBX_CRC_SEED;
            frame_err_ff <= 1'b0;
        end else if (state_ff == mbx_pkg::ST_RECV && rx_valid) begin
            cnt_ff <= rx_byte.first ? 4'h1 : cnt_ff + 4'h1;
            crc_ff <= rx_byte.first
                      ? crc_step(`MBX_CRC_SEED, rx_byte.data) : crc_next;
            frame_err_ff <= rx_byte.first ? 1'b0
                            : (frame_err_ff || cnt_ff >= `MBX_REQ_LEN);
        end
    end

    always_ff @(posedge mclk) begin
        if (state_ff == mbx_pkg::ST_RECV && rx_valid) begin
            if (rx_byte.first) begin
                buf_ff[0] <= rx_byte.data;
            end else if (cnt_ff < `MBX_REQ_LEN) begin
                buf_ff[cnt_ff[2:0]] <= rx_byte.data;
            end
        end
    end

    // Control: check, optionally read, then send.
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_ff <= mbx_pkg::ST_RECV;
            code_ff <= 8'h00;
            exc_ff <= `MBX_EX_NONE;
            tx_idx_ff <= 4'h0;
            tcrc_ff <= `MBX_CRC_SEED;
            tx_valid_ff <= 1'b0;
            tx_byte_ff <= '0;
            unlocked_ff <= 1'b0;
            param_wr_ff <= 1'b0;
            param_wr_value_ff <= 16'h0000;
            attr_addr_ff <= '0;
            rdval_ff <= 16'h0000;
        end else begin
            tx_valid_ff <= 1'b0;
            param_wr_ff <= 1'b0;
            case (state_ff)
                mbx_pkg::ST_RECV: begin
                    attr_addr_ff <= req_addr[AW-1:0];
                    if (rx_valid && rx_byte.last) begin
                        state_ff <= mbx_pkg::ST_CHECK;
                    end
                end
                mbx_pkg::ST_CHECK: begin
                    if (buf_ff[0] != SLAVE_ADDR && !e_frame) begin
                        state_ff <= mbx_pkg::ST_RECV;
                    end else begin
                        exc_ff <= exc_sel;
                        // RL3: echo on success; RL4: top bit on failure.
                        code_ff <= accept ? req_func
                                          : (req_func | `MBX_FC_EXC_BIT);
                        // RL2: store scaled integer; RL12 blocks by accept.
                        param_wr_ff <= accept && is_write && !is_pw;
                        param_wr_value_ff <= req_data;
                        if (accept && is_write && is_pw) begin
                            unlocked_ff <= 1'b1;
                        end
                        tx_idx_ff <= 4'h0;
                        tcrc_ff <= `MBX_CRC_SEED;
                        state_ff <= (accept && is_read) ? mbx_pkg::ST_READ
                                                        : mbx_pkg::ST_SEND;
                    end
                end
                mbx_pkg::ST_READ: begin
                    rdval_ff <= ram_rd;
                    state_ff <= mbx_pkg::ST_SEND;
                end
                mbx_pkg::ST_SEND: begin
                    // RL5: exception body is the code byte then CRC.
                    tx_valid_ff <= 1'b1;
                    tx_byte_ff.data <= tx_sel;
                    tx_byte_ff.first <= tx_idx_ff == 4'h0;
                    tx_byte_ff.last <= tx_idx_ff == rsp_len - 4'h1;
                    if (in_body) begin
                        tcrc_ff <= crc_step(tcrc_ff, tx_sel);
                    end
                    tx_idx_ff <= tx_idx_ff + 4'h1;
                    if (tx_idx_ff == rsp_len - 4'h1) begin
                        state_ff <= mbx_pkg::ST_RECV;
                    end
                end
                default: state_ff <= mbx_pkg::ST_RECV;
            endcase
        end
    end

    // A write refused as read-only never reaches the store.
    a_ro_no_write: // RL12
    assert property (@(posedge mclk) disable iff (reset)
        (state_ff == mbx_pkg::ST_CHECK && e_ro && !e_frame) |=> !param_wr_ff)
        else $error("read-only parameter was written");

    a_exc_topbit: // RL4
    assert property (@(posedge mclk) disable iff (reset)
        (state_ff == mbx_pkg::ST_SEND && exc_ff != `MBX_EX_NONE)
        |-> code_ff[7])
        else $error("exception code lacks top bit");

    a_ok_echo: // RL3
    assert property (@(posedge mclk) disable iff (reset)
        (state_ff == mbx_pkg::ST_SEND && exc_ff == `MBX_EX_NONE)
        |-> code_ff == req_func)
        else $error("normal response changed function code");

    a_exc_length: // RL5
    assert property (@(posedge mclk) disable iff (reset)
        (tx_valid_ff && tx_byte_ff.first && exc_ff != `MBX_EX_NONE)
        |-> ##4 (tx_valid_ff && tx_byte_ff.last))
        else $error("exception response not five bytes");

    a_frame_first: // RL11
    assert property (@(posedge mclk) disable iff (reset)
        (state_ff == mbx_pkg::ST_CHECK && e_frame)
        |=> exc_ff == `MBX_EX_FRAME)
        else $error("frame error not reported first");

    a_func_code: // RL6
    assert property (@(posedge mclk) disable iff (reset)
        (state_ff == mbx_pkg::ST_CHECK && !e_frame && e_func)
        |=> exc_ff == `MBX_EX_FUNC)
        else $error("unsupported function not reported");

    a_lock_code: // RL14
    assert property (@(posedge mclk) disable iff (reset)
        (state_ff == mbx_pkg::ST_CHECK && !e_frame && !e_func && !e_addr
         && !e_data && e_lock) |=> exc_ff == `MBX_EX_LOCKED)
        else $error("locked access not reported");

    a_running_code: // RL13
    assert property (@(posedge mclk) disable iff (reset)
        (state_ff == mbx_pkg::ST_CHECK && exc_sel == `MBX_EX_RUNNING
         && buf_ff[0] == SLAVE_ADDR) |=> !param_wr_ff
         && exc_ff == `MBX_EX_RUNNING)
        else $error("running write not rejected");
endmodule

// ==== mbx_defs.svh ====
`ifndef MBX_DEFS_SVH
`define MBX_DEFS_SVH

// Function codes served by this slave.
`define MBX_FC_READ 8'h03
`define MBX_FC_WRITE 8'h06
`define MBX_FC_EXC_BIT 8'h80

// Exception codes.
`define MBX_EX_NONE 8'h00
`define MBX_EX_FUNC 8'h01
`define MBX_EX_ADDR 8'h02
`define MBX_EX_DATA 8'h03
`define MBX_EX_RANGE 8'h04
`define MBX_EX_PASSWD 8'h05
`define MBX_EX_FRAME 8'h06
`define MBX_EX_RDONLY 8'h07
`define MBX_EX_RUNNING 8'h08
`define MBX_EX_LOCKED 8'h09

// Password address, parameter space size and read quantity limit.
`define MBX_PASSWD_ADDR 16'h0000
`define MBX_PARAM_COUNT 16'h0100
`define MBX_MAX_READ_QTY 16'h000c

// Request frame length in bytes for both supported functions.
`define MBX_REQ_LEN 4'h8

// CRC-16 polynomial, reflected, and its seed.
`define MBX_CRC_POLY 16'ha001
`define MBX_CRC_SEED 16'hffff

// Byte counts of the response kinds.
`define MBX_RSP_EXC_LEN 4'h5
`define MBX_RSP_WR_LEN 4'h8
`define MBX_RSP_RD_LEN 4'h7

// Fixed-point scale base; no logic converts, values are stored as received.
`define MBX_SCALE_BASE 16'h000a

`endif

// ==== mbx_pkg.sv ====
package mbx_pkg;

    // A byte travelling with its frame delimiters.
    typedef struct packed {
        logic [7:0] data;
        logic first;
        logic last;
    } mbx_byte_s;

    // One parameter's attributes held beside its value.
    typedef struct packed {
        logic read_only;
        logic stop_only;
        logic [1:0] decimals;
        logic [15:0] min_val;
        logic [15:0] max_val;
    } mbx_attr_s;

    typedef enum logic [2:0] {
        ST_RECV,
        ST_CHECK,
        ST_READ,
        ST_SEND
    } mbx_state_e;

endpackage

// ==== mbx_param_ram.sv ====
`timescale 1ns/1ns
// Parameter store; read data come out of a register one cycle later.
module mbx_param_ram #(
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic mclk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [15:0] rd_data
);
    logic [15:0] mem [DEPTH];

    // No reset on the array itself keeps it mappable to block RAM.
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// ==== mbx_master_model.sv ====
`timescale 1ns/1ns
// Bus master stand-in: sends whole request frames and gathers the reply.
module mbx_master_model (
    input wire logic mclk,
    output mbx_pkg::mbx_byte_s rx_byte,
    output logic rx_valid,
    input wire mbx_pkg::mbx_byte_s tx_byte,
    input wire logic tx_valid
);
    logic [7:0] rsp[$];
    bit done;

    // Nothing is offered until the bench asks for a frame.
    initial begin
        rx_byte = '0;
        rx_valid = 1'b0;
    end

    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int b = 0; b < 8; b++)
                c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
        end
        return c;
    endfunction

    // Every reply byte is kept; the last mark ends the wait.
    always @(posedge mclk) begin
        if (tx_valid) begin
            rsp.push_back(tx_byte.data);
            if (tx_byte.last)
                done = 1;
        end
    end

    // One byte a cycle; a set bad flag spoils the check on purpose.
    task automatic send(input logic [7:0] q[$], input bit bad);
        logic [15:0] c;
        c = crc16(q) ^ {15'h0000, bad};
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        rsp.delete();
        done = 0;
        foreach (q[i]) begin
            @(posedge mclk);
            #1;
            rx_byte = '{data: q[i], first: i == 0, last: i == q.size() - 1};
            rx_valid = 1'b1;
        end
        @(posedge mclk);
        #1;
        rx_valid = 1'b0;
        // Idle data is scrambled so a stale byte is never mistaken.
        rx_byte.data = ~rx_byte.data;
        for (int k = 0; k < 40 && !done; k++) begin
            @(posedge mclk);
            #1;
        end
    endtask
endmodule

// ==== modbus_slave_exception_responder_bench.sv ====
`timescale 1ns/1ns
`include "mbx_defs.svh"
// Compares, counts and reports one value.
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    err_count++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module modbus_slave_exception_responder_bench;
    logic mclk, reset, rx_valid, tx_valid, unlocked, param_wr;
    logic drive_running, drive_faulted;
    logic [15:0] pw_set, wr_val, wr_value_w, rd_exp;
    logic [7:0] attr_addr;
    mbx_pkg::mbx_byte_s rx_byte, tx_byte;
    mbx_pkg::mbx_attr_s attr_v;
    int err_count, checks_done, wr_cnt;

    mbx_responder i_mbx_responder (.mclk(mclk), .reset(reset),
        .rx_byte(rx_byte), .rx_valid(rx_valid),
        .drive_running(drive_running), .drive_faulted(drive_faulted),
        .user_password_setting(pw_set), .attr(attr_v),
        .attr_addr_ff(attr_addr), .tx_byte_ff(tx_byte),
        .tx_valid_ff(tx_valid), .unlocked_ff(unlocked),
        .param_wr_ff(param_wr), .param_wr_value_ff(wr_value_w));
    mbx_master_model i_mbx_master_model (.mclk(mclk), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .tx_byte(tx_byte), .tx_valid(tx_valid));

    // Free-running system clock.
    initial begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end

    // Store writes are counted so that refused ones can be seen to vanish.
    always @(posedge mclk) begin
        if (param_wr) begin
            wr_cnt <= wr_cnt + 1;
            wr_val <= wr_value_w;
        end
    end

    task automatic set_attr(input bit ro, input bit so, logic [15:0] mx);
        attr_v = {ro, so, 2'h1, 16'h0000, mx};
    endtask

    // Sends one request and checks the whole reply against its expectation.
    task automatic run(input logic [7:0] fc, input logic [15:0] a, v,
        input logic [7:0] code, input bit bad = 0);
        logic [7:0] req[$];
        logic [7:0] exp[$];
        logic [15:0] c;
        int n;
        req = {8'h01, fc, a[15:8], a[7:0], v[15:8], v[7:0]};
        n = wr_cnt;
        i_mbx_master_model.send(req, bad);
        if (code != `MBX_EX_NONE)
            exp = {8'h01, fc | `MBX_FC_EXC_BIT, code};
        else if (fc == `MBX_FC_READ)
            exp = {8'h01, fc, 8'h02, rd_exp[15:8], rd_exp[7:0]};
        else
            exp = req;
        c = i_mbx_master_model.crc16(exp);
        exp.push_back(c[7:0]);
        exp.push_back(c[15:8]);
        `CHK("rsp_len", exp.size(), i_mbx_master_model.rsp.size())
        foreach (exp[i])
            `CHK("rsp_byte", exp[i], i_mbx_master_model.rsp[i])
        `CHK("wr_count", int'(code == 0 && fc == 6 && a != 0), wr_cnt - n)
    endtask

    // A value of 5.0 with one decimal travels as 50 and reads back.
    task automatic t_write_read;
        set_attr(0, 0, 16'hffff);
        run(8'h06, 16'h0005, 16'h0032, 8'h00);
        `CHK("wr_value", 16'h0032, wr_val)
        rd_exp = 16'h0032;
        run(8'h03, 16'h0005, 16'h0001, 8'h00);
    endtask

    // A spoilt check wins over a bad function code.
    task automatic t_frame_func;
        run(8'h04, 16'h0005, 16'h0001, 8'h06, 1);
        run(8'h04, 16'h0005, 16'h0001, 8'h01);
        drive_faulted = 1;
        run(8'h06, 16'h0005, 16'h0001, 8'h01);
        drive_faulted = 0;
    endtask

    // Address limits on both functions, span and quantity limits on reads.
    task automatic t_addr_data;
        run(8'h06, 16'h0100, 16'h0001, 8'h02);
        run(8'h03, 16'h00ff, 16'h0002, 8'h02);
        run(8'h03, 16'h0005, 16'h0000, 8'h03);
        run(8'h03, 16'h0005, 16'h000d, 8'h03);
    endtask

    // Access rights come before the range check.
    task automatic t_access;
        set_attr(1, 0, 16'h0002);
        run(8'h06, 16'h0001, 16'h0003, 8'h07);
        set_attr(0, 1, 16'h0002);
        drive_running = 1;
        run(8'h06, 16'h0001, 16'h0001, 8'h08);
        drive_running = 0;
        run(8'h06, 16'h0001, 16'h0003, 8'h04);
        run(8'h06, 16'h0001, 16'h0002, 8'h00);
    endtask

    // Locked access, a wrong then a right password, and reset relocking.
    task automatic t_lock;
        pw_set = 16'h1234;
        run(8'h03, 16'h0001, 16'h0001, 8'h09);
        run(8'h06, 16'h0000, 16'h1111, 8'h05);
        run(8'h06, 16'h0000, 16'h1234, 8'h00);
        `CHK("unlocked", 1'b1, unlocked)
        rd_exp = 16'h0002;
        run(8'h03, 16'h0001, 16'h0001, 8'h00);
        reset = 1;
        @(posedge mclk);
        #1;
        reset = 0;
        `CHK("relock", 1'b0, unlocked)
        pw_set = 16'h0000;
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Main sequence after ten cycles of reset.
    initial begin
        reset = 1;
        drive_running = 0;
        drive_faulted = 0;
        pw_set = 16'h0000;
        attr_v = '0;
        rd_exp = 16'h0000;
        wr_cnt = 0;
        err_count = 0;
        checks_done = 0;
        repeat (10) @(posedge mclk);
        #1;
        reset = 0;
        t_write_read;
        t_frame_func;
        t_addr_data;
        t_access;
        t_lock;
        results;
    end

    // A hang is cut short well past the expected run length.
    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        results;
    end
endmodule
